// *** logic/asrx_fifo.sv ***
// asrx_fifo: two-entry character store, nine data bits plus framing flag
// a push when full is dropped even alongside a pop; pop on empty is ignored
`timescale 1ns/10ps
module asrx_fifo (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // flush on port disable
  input wire logic flush,
  // write side
  input wire logic push,
  input wire logic [9:0] push_data,
  // read side
  input wire logic pop,
  output logic [9:0] head,
  output logic [1:0] count
);
  import asrx_pkg::*;

  typedef struct packed {
    logic [ASRX_FIFO_DEPTH-1:0][9:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
  } asrx_fifo_s;

  asrx_fifo_s st_r;
  asrx_fifo_s st_nxt;
  logic do_push;
  logic do_pop;

  // pointers and count; a push on full is refused even with a pop, and an accepted push and pop together keep the count
  always_comb begin
    st_nxt = st_r;
    do_push = push && (st_r.count != ASRX_FIFO_FULL);
    do_pop = pop && (st_r.count != 2'h0);
    if (do_push) begin
      st_nxt.mem[st_r.wr_ptr] = push_data;
      st_nxt.wr_ptr = ~st_r.wr_ptr;
    end
    if (do_pop) begin
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    end
    if (do_push && !do_pop) begin
      st_nxt.count = st_r.count + ASRX_ONE2;
    end else if (do_pop && !do_push) begin
      st_nxt.count = st_r.count - ASRX_ONE2;
    end
    if (flush) begin
      st_nxt.rd_ptr = 1'b0;
      st_nxt.wr_ptr = 1'b0;
      st_nxt.count = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign head = st_r.mem[st_r.rd_ptr];
  assign count = st_r.count;
endmodule

// *** logic/asrx_receiver.sv ***
// asrx_receiver: asynchronous serial receiver with register port
// assumes the receive line is already synchronous to clk and idles high
`timescale 1ns/10ps

module asrx_receiver (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial line
  input wire logic receive_line_pin,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // status
  output logic receive_pending_flag,
  output logic receiver_idle_status
);
  import asrx_pkg::*;

  typedef struct packed {
    logic [7:0] transmit_status_control_reg;
    logic [7:0] baudcon;
    logic [7:0] receive_status_control_reg;
    logic [15:0] divisor;
    asrx_state_e state;
    logic [3:0] ovs;
    logic [3:0] bitcnt;
    logic [8:0] shifter;
    logic [2:0] votes;
    logic line_d;
    logic overrun;
    logic pending;
    logic idle;
    logic [7:0] rdata;
  } asrx_rx_s;

  asrx_rx_s st_r;
  asrx_rx_s st_nxt;
  logic tick;
  logic run;
  logic [15:0] eff_div;
  logic push;
  logic [9:0] push_data;
  logic pop;
  logic [9:0] head;
  logic [1:0] count;
  logic flush;
  logic majority;

  // two-of-three vote over the samples taken around the bit centre
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // decode of a register index, used by both read and write paths
  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction

  assign run = st_r.receive_status_control_reg[ASRX_RS_SERIAL_PORT_ENABLE] && st_r.receive_status_control_reg[ASRX_RS_CONTINUOUS_RECEIVE_ENABLE] &&
               !st_r.transmit_status_control_reg[ASRX_TS_SYNC];
  assign flush = !st_r.receive_status_control_reg[ASRX_RS_SERIAL_PORT_ENABLE];
  // divisor shared with the transmit side, 8-bit unless wide select set
  assign eff_div = st_r.baudcon[ASRX_BC_WIDE_DIVISOR_SELECT] ? st_r.divisor : {8'h00, st_r.divisor[7:0]};
  // a data read removes the oldest entry
  assign pop = reg_rd && hit(reg_addr, ASRX_ADDR_RXDATA);
  // votes must come from the bit being decided, so the live pin is the third sample
  assign majority = vote3({st_r.votes[1:0], receive_line_pin});

  // oversampling enable at sixteen ticks per bit
  asrx_tick u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .run(run),
    .divisor(eff_div),
    .tick(tick)
  );

  // two-deep character store, framing bit on top
  asrx_fifo u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .flush(flush),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .head(head),
    .count(count)
  );

  // recovery engine, register writes and read data
  always_comb begin
    st_nxt = st_r;
    push = 1'b0;
    push_data = '0;
    st_nxt.rdata = ASRX_BYTE_RST;
    // register writes; status bits stay hardware-owned
    if (reg_wr) begin
      if (hit(reg_addr, ASRX_ADDR_TRANSMIT_STATUS_CONTROL_REG)) begin
        st_nxt.transmit_status_control_reg = reg_wdata;
      end
      if (hit(reg_addr, ASRX_ADDR_BAUDCON)) begin
        st_nxt.baudcon = reg_wdata;
      end
      if (hit(reg_addr, ASRX_ADDR_RXSTA)) begin
        st_nxt.receive_status_control_reg = {reg_wdata[7:3], 3'h0};
      end
      if (hit(reg_addr, ASRX_ADDR_DIVLO)) begin
        st_nxt.divisor[7:0] = reg_wdata;
      end
      if (hit(reg_addr, ASRX_ADDR_DIVHI)) begin
        st_nxt.divisor[15:8] = reg_wdata;
      end
    end
    if (tick) begin
      st_nxt.ovs = st_r.ovs + ASRX_ONE4;
      if (st_r.ovs == ASRX_VOTE_A || st_r.ovs == ASRX_VOTE_B) begin
        st_nxt.votes = {st_r.votes[1:0], receive_line_pin};
      end
      st_nxt.line_d = receive_line_pin;
      case (st_r.state)
        ASRX_IDLE: begin
          // falling edge opens the start bit
          if (st_r.line_d && !receive_line_pin) begin
            st_nxt.state = ASRX_START;
            st_nxt.ovs = '0;
            st_nxt.idle = 1'b0;
          end
        end
        ASRX_START: begin
          // mid-bit recheck, quiet abort if high
          if (st_r.ovs == ASRX_OVS_HALF) begin
            if (receive_line_pin) begin
              st_nxt.state = ASRX_IDLE;
              st_nxt.idle = 1'b1;
            end else begin
              st_nxt.state = ASRX_DATA;
              // restart the count at the start centre: ovs wraps to last at the next centre
              st_nxt.ovs = '0;
              st_nxt.bitcnt = '0;
            end
          end
        end
        ASRX_DATA: begin
          // vote lands at the centre, one bit period apart
          if (st_r.ovs == ASRX_OVS_LAST) begin
            // lsb first, so shift in from the top
            if (st_r.receive_status_control_reg[ASRX_RS_RX9]) begin
              st_nxt.shifter = {majority, st_r.shifter[8:1]};
            end else begin
              st_nxt.shifter = {1'b0, majority, st_r.shifter[7:1]};
            end
            st_nxt.bitcnt = st_r.bitcnt + ASRX_ONE4;
            if (st_nxt.bitcnt == (st_r.receive_status_control_reg[ASRX_RS_RX9] ? ASRX_BITS9 : ASRX_BITS8)) begin
              st_nxt.state = ASRX_STOP;
            end
          end
        end
        ASRX_STOP: begin
          if (st_r.ovs == ASRX_OVS_LAST) begin
            st_nxt.state = ASRX_IDLE;
            st_nxt.idle = 1'b1;
            // address mode drops characters with ninth bit clear
            if (!(st_r.receive_status_control_reg[ASRX_RS_ADDRESS_DETECT_ENABLE] && st_r.receive_status_control_reg[ASRX_RS_RX9] &&
                  !st_r.shifter[8])) begin
              if (st_r.overrun) begin
                // overrun holds off all further characters
              end else if (count == ASRX_FIFO_FULL && !pop) begin
                st_nxt.overrun = 1'b1;
              end else begin
                // framing bit follows the stop sample
                // push at the stop bit centre
                push = 1'b1;
                push_data = {!majority, st_r.shifter};
              end
            end
          end
        end
        default: begin
          st_nxt.state = ASRX_IDLE;
        end
      endcase
    end
    // overrun clears when either enable drops
    if (!st_r.receive_status_control_reg[ASRX_RS_CONTINUOUS_RECEIVE_ENABLE] || !st_r.receive_status_control_reg[ASRX_RS_SERIAL_PORT_ENABLE]) begin
      st_nxt.overrun = 1'b0;
    end
    // idle the recovery logic when not running
    if (!run) begin
      st_nxt.state = ASRX_IDLE;
      st_nxt.idle = 1'b1;
      st_nxt.ovs = '0;
      st_nxt.line_d = 1'b1;
    end
    // pending while enabled and something unread
    st_nxt.pending = st_r.receive_status_control_reg[ASRX_RS_CONTINUOUS_RECEIVE_ENABLE] && st_r.receive_status_control_reg[ASRX_RS_SERIAL_PORT_ENABLE] &&
                     (count != 2'h0);
    // read data, valid the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        ASRX_ADDR_TRANSMIT_STATUS_CONTROL_REG: begin
          st_nxt.rdata = st_r.transmit_status_control_reg;
          // transmitter absent here, its shifter always reads empty
          st_nxt.rdata[ASRX_TS_TRMT] = 1'b1;
        end
        ASRX_ADDR_BAUDCON: begin
          st_nxt.rdata = st_r.baudcon;
          st_nxt.rdata[ASRX_BC_IDLE] = st_r.idle;
        end
        ASRX_ADDR_RXDATA: begin
          st_nxt.rdata = (count != 2'h0) ? head[7:0] : ASRX_BYTE_RST;
        end
        ASRX_ADDR_RXSTA: begin
          st_nxt.rdata = st_r.receive_status_control_reg;
          // follows the head entry, emptied by a data read or a port disable flush
          st_nxt.rdata[ASRX_RS_FRAMING_ERROR] = (count != 2'h0) && head[9];
          st_nxt.rdata[ASRX_RS_OVERRUN_ERROR] = st_r.overrun;
          // ninth bit of the head entry
          st_nxt.rdata[ASRX_RS_RECEIVED_NINTH_BIT] = (count != 2'h0) && head[8];
        end
        ASRX_ADDR_DIVLO: begin
          st_nxt.rdata = st_r.divisor[7:0];
        end
        ASRX_ADDR_DIVHI: begin
          st_nxt.rdata = st_r.divisor[15:8];
        end
        default: begin
          st_nxt.rdata = ASRX_BYTE_RST;
        end
      endcase
    end
  end

  // single register bank for all state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.transmit_status_control_reg <= ASRX_TRANSMIT_STATUS_CONTROL_REG_RST;
      st_r.state <= ASRX_IDLE;
      st_r.line_d <= 1'b1;
      st_r.idle <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign receive_pending_flag = st_r.pending;
  assign receiver_idle_status = st_r.idle;
endmodule

// *** logic/asrx_tick.sv ***
// asrx_tick: divider giving the 16x oversampling enable pulse
// assumes the divisor is held steady by software while the port runs
`timescale 1ns/10ps
module asrx_tick (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [15:0] divisor,
  // output enable pulse
  output logic tick
);
  import asrx_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } asrx_tick_s;

  asrx_tick_s st_r;
  asrx_tick_s st_nxt;

  // count down the divisor, one tick per wrap; held at the divisor while stopped
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = divisor;
    end else if (st_r.cnt == ASRX_DIV_RST) begin
      st_nxt.cnt = divisor;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt - ASRX_ONE16;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule

// *** shared/asrx_pkg.sv ***
// asrx_pkg: register map, field positions, reset values and timing for the serial receiver
// assumes one 10 MHz clock; no offsets are printed, so the map below is local
package asrx_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ASRX_ADDR_TRANSMIT_STATUS_CONTROL_REG = 3'h0;
  localparam logic [2:0] ASRX_ADDR_BAUDCON = 3'h1;
  localparam logic [2:0] ASRX_ADDR_RXDATA = 3'h2;
  localparam logic [2:0] ASRX_ADDR_RXSTA = 3'h3;
  localparam logic [2:0] ASRX_ADDR_DIVLO = 3'h4;
  localparam logic [2:0] ASRX_ADDR_DIVHI = 3'h5;
  // receive_status_control fields
  localparam int ASRX_RS_SERIAL_PORT_ENABLE = 7;
  localparam int ASRX_RS_RX9 = 6;
  localparam int ASRX_RS_SREN = 5;
  localparam int ASRX_RS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int ASRX_RS_ADDRESS_DETECT_ENABLE = 3;
  localparam int ASRX_RS_FRAMING_ERROR = 2;
  localparam int ASRX_RS_OVERRUN_ERROR = 1;
  localparam int ASRX_RS_RECEIVED_NINTH_BIT = 0;
  // transmit_status_control fields; SYNC and TRMT are used here
  localparam int ASRX_TS_SYNC = 4;
  localparam int ASRX_TS_HIGH_BIT_RATE_SELECT = 2;
  localparam int ASRX_TS_TRMT = 1;
  // baud_control fields
  localparam int ASRX_BC_IDLE = 6;
  localparam int ASRX_BC_WIDE_DIVISOR_SELECT = 3;
  // reset values
  localparam logic [7:0] ASRX_TRANSMIT_STATUS_CONTROL_REG_RST = 8'h02;
  localparam logic [7:0] ASRX_BYTE_RST = 8'h00;
  localparam logic [15:0] ASRX_DIV_RST = 16'h0000;
  // oversampling and character format
  localparam int ASRX_OVS = 16;
  localparam logic [3:0] ASRX_OVS_LAST = 4'hf;
  localparam logic [3:0] ASRX_OVS_HALF = 4'h7;
  // two early samples just before the decision tick; the third is the decision tick itself
  localparam logic [3:0] ASRX_VOTE_A = 4'hd;
  localparam logic [3:0] ASRX_VOTE_B = 4'he;
  localparam logic [3:0] ASRX_BITS8 = 4'h8;
  localparam logic [3:0] ASRX_BITS9 = 4'h9;
  localparam int ASRX_FIFO_DEPTH = 2;
  localparam logic [1:0] ASRX_FIFO_FULL = 2'h2;
  localparam logic [1:0] ASRX_ONE2 = 2'h1;
  localparam logic [3:0] ASRX_ONE4 = 4'h1;
  localparam logic [15:0] ASRX_ONE16 = 16'h0001;
  // data recovery states, one-hot
  typedef enum logic [3:0] {
    ASRX_IDLE = 4'h1,
    ASRX_START = 4'h2,
    ASRX_DATA = 4'h4,
    ASRX_STOP = 4'h8
  } asrx_state_e;
endpackage

// *** testbench/asrx_receiver_chk.sv ***
// asrx_receiver_chk: port-level checks of the serial receiver
// assumes one clock domain and software that keeps the port enabled mid-frame
`timescale 1ns/10ps
module asrx_receiver_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial line and register port
  input wire logic receive_line_pin,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // status
  input wire logic receive_pending_flag,
  input wire logic receiver_idle_status
);
  import asrx_pkg::*;
  logic en_r;
  logic [3:0] act_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // shadow of both enables, as last written
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r <= 1'b0;
    end else if (reg_wr && reg_addr == ASRX_ADDR_RXSTA) begin
      en_r <= reg_wdata[ASRX_RS_SERIAL_PORT_ENABLE] & reg_wdata[ASRX_RS_CONTINUOUS_RECEIVE_ENABLE];
    end
  end
  // cycles since the last data read or any write, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      act_r <= 4'hf;
    end else if ((reg_rd && reg_addr == ASRX_ADDR_RXDATA) || reg_wr) begin
      act_r <= 4'h0;
    end else if (act_r != 4'hf) begin
      act_r <= act_r + 4'h1;
    end
  end
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer cycle");
  property p_pend_drop;
    $fell(receive_pending_flag) |-> act_r <= 4'h3;
  endproperty
  a_pend_drop: assert property (p_pend_drop)
    else $error("pending dropped without a read");
  property p_no_start;
    receiver_idle_status && receive_line_pin && $past(receive_line_pin) |=> receiver_idle_status;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("left idle without falling edge");
  property p_half_bit;
    $fell(receiver_idle_status) |-> !receiver_idle_status [*6];
  endproperty
  a_half_bit: assert property (p_half_bit)
    else $error("start abandoned too early");
  property p_frame_end;
    $fell(receiver_idle_status) |-> ##[1:1000] receiver_idle_status;
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("frame never ended");
  property p_pend_enabled;
    !en_r && !$past(en_r) |-> !receive_pending_flag;
  endproperty
  a_pend_enabled: assert property (p_pend_enabled)
    else $error("pending while receiver disabled");
  property p_port_off;
    reg_wr && reg_addr == ASRX_ADDR_RXSTA && !reg_wdata[ASRX_RS_SERIAL_PORT_ENABLE]
      |-> ##3 (!receive_pending_flag && receiver_idle_status);
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("port disable did not flush");
  property p_trmt;
    reg_rd && reg_addr == ASRX_ADDR_TRANSMIT_STATUS_CONTROL_REG |=> reg_rdata[ASRX_TS_TRMT];
  endproperty
  a_trmt: assert property (p_trmt)
    else $error("transmit empty bit reads low");
endmodule
bind asrx_receiver asrx_receiver_chk asrx_receiver_chk_inst (
  .clk(clk), .reset_n(reset_n), .receive_line_pin(receive_line_pin),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .receive_pending_flag(receive_pending_flag),
  .receiver_idle_status(receiver_idle_status)
);

// *** testbench/asrx_receiver_test.sv ***
// asrx_receiver_test: self-checking bench for the serial receiver
// assumes divisor 0, so one bit is 16 clocks of 100 ns
`timescale 1ns/10ps
module asrx_receiver_test;
  import asrx_pkg::*;
  typedef struct {logic [7:0] cfg; logic [8:0] d; logic stp; logic [7:0] sta;} asrx_row_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic line;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic pend;
  logic idle;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] rst_exp [8] = '{8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // control byte, character, stop level, expected status
  asrx_row_s rows [5] = '{'{8'h90, 9'h0a5, 1'b1, 8'h90}, '{8'h90, 9'h03c, 1'b0, 8'h94},
    '{8'hd0, 9'h15a, 1'b1, 8'hd1}, '{8'hd0, 9'h0ff, 1'b1, 8'hd0},
    '{8'hd8, 9'h1c3, 1'b1, 8'hd9}};
  // 10 MHz clock
  always #50 clk = ~clk;
  asrx_tx_model asrx_tx_model_inst (.clk(clk), .line(line));
  asrx_receiver asrx_receiver_inst (
    .clk(clk), .reset_n(reset_n), .receive_line_pin(line), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .receive_pending_flag(pend), .receiver_idle_status(idle)
  );
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // answer stands one cycle only, so it is sampled mid-cycle
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic wait_pend();
    int n;
    n = 0;
    while (pend !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n == 600) begin
      errors++;
      $display("unexpected at %0t: pending never rose", $time);
      report_and_stop();
    end
  endtask
  // hang guard
  initial begin
    #3000000;
    errors++;
    $display("unexpected at %0t: run too long", $time);
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 8; a++) if (a != 2) rchk(a[2:0], rst_exp[a]);
    // rate first, then port mode, then enables; line model is a plain input
    wr_reg(ASRX_ADDR_DIVLO, 8'h00);
    wr_reg(ASRX_ADDR_TRANSMIT_STATUS_CONTROL_REG, 8'h00);
    wr_reg(ASRX_ADDR_RXSTA, 8'h90);
    asrx_tx_model_inst.glitch();
    chk({7'h00, pend}, 8'h00);
    chk({7'h00, idle}, 8'h01);
    foreach (rows[i]) begin
      wr_reg(ASRX_ADDR_RXSTA, rows[i].cfg);
      asrx_tx_model_inst.send(rows[i].d, rows[i].cfg[ASRX_RS_RX9], rows[i].stp);
      wait_pend();
      // status and ninth bit read before the data
      rchk(ASRX_ADDR_RXSTA, rows[i].sta);
      rchk(ASRX_ADDR_RXDATA, rows[i].d[7:0]);
    end
    // ninth bit clear in address mode is dropped
    asrx_tx_model_inst.send(9'h011, 1'b1, 1'b1);
    chk({7'h00, pend}, 8'h00);
    // address mode left before plain data follows
    // four characters into a two-deep store
    wr_reg(ASRX_ADDR_RXSTA, 8'h90);
    for (int k = 1; k < 5; k++) asrx_tx_model_inst.send({1'b0, k[3:0], k[3:0]}, 1'b0, 1'b1);
    rchk(ASRX_ADDR_RXSTA, 8'h92);
    rchk(ASRX_ADDR_RXDATA, 8'h11);
    rchk(ASRX_ADDR_RXDATA, 8'h22);
    repeat (3) @(negedge clk);
    chk({7'h00, pend}, 8'h00);
    wr_reg(ASRX_ADDR_RXSTA, 8'h80);
    rchk(ASRX_ADDR_RXSTA, 8'h80);
    // framing flag survives receive disable, not port disable
    wr_reg(ASRX_ADDR_RXSTA, 8'h90);
    asrx_tx_model_inst.send(9'h055, 1'b0, 1'b0);
    wait_pend();
    wr_reg(ASRX_ADDR_RXSTA, 8'h80);
    rchk(ASRX_ADDR_RXSTA, 8'h84);
    chk({7'h00, pend}, 8'h00);
    wr_reg(ASRX_ADDR_RXSTA, 8'h00);
    rchk(ASRX_ADDR_RXSTA, 8'h00);
    wr_reg(ASRX_ADDR_RXSTA, 8'h90);
    repeat (3) @(negedge clk);
    chk({7'h00, pend}, 8'h00);
    report_and_stop();
  end
endmodule

// *** testbench/asrx_tx_model.sv ***
// asrx_tx_model: remote transmitter driving the receive line
// assumes divisor 0 in the receiver, so one bit lasts BIT_CLKS clocks
`timescale 1ns/10ps
module asrx_tx_model #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input wire logic clk,
  // serial line, idles high
  output logic line
);
  // line idles high between frames
  initial line = 1'b1;
  task automatic send(input logic [8:0] d, input logic nine, input logic stop_ok);
    logic [10:0] f;
    f = nine ? {stop_ok, d, 1'b0} : {1'b1, stop_ok, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    // a low stop level must not hide the next falling edge
    @(posedge clk);
    line <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  // short low pulse, no real start bit
  task automatic glitch();
    @(posedge clk);
    line <= 1'b0;
    repeat (3) @(posedge clk);
    line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask
endmodule
